// >>> pkg/bis_consts.svh
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH

// Clock and timing figures
`define BIS_CLK_HZ         25000000
`define BIS_TICK_S         1
`define BIS_LOSS_FAST_MS   800
`define BIS_LOSS_SLOW_MS   3000
`define BIS_JUMPER_LOCK_H  200
`define BIS_SECS_PER_HOUR  3600
`define BIS_INITIATE_S     8'h0a
`define BIS_AIRFLOW_WAIT_S 8'h0a
`define BIS_TRIAL_LONG_S   8'h0a
`define BIS_TRIAL_SHORT_S  8'h04
`define BIS_TEST_LONG_S    8'h08
`define BIS_TEST_SHORT_S   8'h03
`define BIS_MAIN_TRIAL_S   8'h0a
`define BIS_POSTPURGE_S    8'h0f
`define BIS_FLAMEOUT_S     8'h0f

// Register byte addresses
`define BIS_ADDR_CONFIG    8'h00
`define BIS_ADDR_CONTROL   8'h04
`define BIS_ADDR_STATUS    8'h08
`define BIS_ADDR_SECONDS   8'h0c

// Reset values and field positions
`define BIS_CONFIG_RESET   13'h0140
`define BIS_CONFIG_MSB     12
`define BIS_CTRL_RESET_BIT 0

// Fault codes
`define BIS_CODE_NONE      8'h00
`define BIS_CODE_NO_FLAME  8'h01
`define BIS_CODE_FLAME_FAIL 8'h02
`define BIS_CODE_AIRFLOW   8'h03
`define BIS_CODE_FLAMEOUT  8'h04
`define BIS_CODE_JUMPER    8'h6e

`endif

// >>> pkg/bis_pkg.sv
`default_nettype none
package bis_pkg;

  typedef enum logic [3:0] {
    st_initiate,
    st_standby,
    st_prepurge,
    st_pilot,
    st_main_trial,
    st_run,
    st_postpurge,
    st_lockout,
    st_fault
  } bis_state_type;

  // Software-set variant options
  typedef struct packed {
    logic [7:0] prepurge_s;
    logic       slow_response;
    logic       valves_jumpered;
    logic       post_purge;
    logic       delayed_main;
    logic       interrupted_pilot;
  } bis_config_type;

  // Site jumpers, 1 means clipped
  typedef struct packed {
    logic trial_short;
    logic flame_lockout;
    logic airflow_lockout;
  } bis_jumpers_type;

  typedef struct packed {
    logic pilot;
    logic ignition;
    logic main;
    logic delayed_main;
    logic blower;
    logic alarm;
  } bis_outputs_type;

endpackage
`default_nettype wire

// >>> hw/bis_sequencer.sv
`include "bis_consts.svh"
`default_nettype none

module bis_sequencer
  import bis_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = `BIS_TICK_S * `BIS_CLK_HZ,
  parameter int unsigned FAST_CYCLES  =
    `BIS_LOSS_FAST_MS * (`BIS_CLK_HZ / 1000),
  parameter int unsigned SLOW_CYCLES  =
    `BIS_LOSS_SLOW_MS * (`BIS_CLK_HZ / 1000),
  parameter int unsigned LOCK_SECONDS =
    `BIS_JUMPER_LOCK_H * `BIS_SECS_PER_HOUR
)(
  input  wire logic        hclk,                 // System clock
  input  wire logic        hresetn,              // Async reset, low
  input  wire logic        hsel,                 // Slave select
  input  wire logic [31:0] haddr,                // Byte address
  input  wire logic [1:0]  htrans,               // Transfer type
  input  wire logic        hwrite,               // Write not read
  input  wire logic [2:0]  hsize,                // Word only
  input  wire logic [31:0] hwdata,               // Write data
  input  wire logic        hready,               // Bus ready
  output logic             hreadyout,            // Slave ready
  output logic [31:0]      hrdata,               // Read data
  output logic             hresp,                // Always OKAY
  input  wire logic        flame,                // Flame proven
  input  wire logic        demand,               // Demand and limits
  input  wire logic        airflow,              // Airflow interlock
  input  wire logic        run_test,             // 1 = test position
  input  wire logic        trial_length_jumper,  // 1 = clipped
  input  wire logic        flame_fail_action_jumper,   // 1 = clipped
  input  wire logic        airflow_fail_action_jumper, // 1 = clipped
  output logic             pilot_valve,          // Pilot valve
  output logic             ignition,             // Ignition transformer
  output logic             main_valve,           // Main fuel valve
  output logic             delayed_main_valve,   // Delayed main valve
  output logic             blower,               // Blower motor
  output logic             alarm                 // Lockout or fault
);

  bis_state_type   state;
  bis_state_type   next_state;
  bis_config_type  cfg;
  bis_jumpers_type jumpers;
  bis_jumpers_type jumper_ref;
  bis_outputs_type outs;
  logic [24:0]     tick_count;
  logic            tick;
  logic [7:0]      phase_secs;
  logic [7:0]      flameout_secs;
  logic [26:0]     loss_count;
  logic [19:0]     op_secs;
  logic [7:0]      fault_code;
  logic [7:0]      next_code;
  logic            restart;
  logic            flame_proven;
  logic            held;
  logic            flame_fail;
  logic            lock_passed;
  logic            jumper_fault;
  logic [7:0]      trial_len;
  logic [7:0]      test_limit;
  logic            wr_pend;
  logic [7:0]      wr_addr;
  logic            lockout_reset;
  logic            accept;

  assign jumpers = {trial_length_jumper, flame_fail_action_jumper,
                    airflow_fail_action_jumper};

  // Trial length and test window from the live jumper
  assign trial_len  = jumpers.trial_short ? `BIS_TRIAL_SHORT_S
                                          : `BIS_TRIAL_LONG_S;
  assign test_limit = jumpers.trial_short ? `BIS_TEST_SHORT_S
                                          : `BIS_TEST_LONG_S;

  // Test holds prepurge, and the pilot only early in the trial and only with valves not jumpered
  assign held = run_test &&
    ((state == st_prepurge) ||
     (state == st_pilot && !cfg.valves_jumpered &&
      phase_secs < test_limit));

  // Flame lost for longer than the amplifier's response class
  assign flame_fail = loss_count >= (cfg.slow_response ?
    27'(SLOW_CYCLES - 1) : 27'(FAST_CYCLES - 1));

  assign lock_passed  = op_secs >= 20'(LOCK_SECONDS);
  assign jumper_fault = lock_passed && (jumpers != jumper_ref);

  // One-second tick from the system clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_count <= 25'h0000000;
      tick       <= 1'b0;
    end
    else if (tick_count == 25'(TICK_CYCLES - 1))
    begin
      tick_count <= 25'h0000000;
      tick       <= 1'b1;
    end
    else
    begin
      tick_count <= tick_count + 25'h0000001;
      tick       <= 1'b0;
    end
  end

  // Sequence decisions
  always_comb
  begin
    next_state = state;
    next_code  = fault_code;
    restart    = 1'b0;
    case (state)
      st_initiate:
        if (phase_secs >= `BIS_INITIATE_S)
          next_state = st_standby;
      st_standby:
        if (demand)
          next_state = st_prepurge;
      st_prepurge:
        if (!demand)
          next_state = st_standby;
        else if (!airflow && phase_secs >= `BIS_AIRFLOW_WAIT_S)
        begin
          if (jumpers.airflow_lockout)
          begin
            next_state = st_lockout;
            next_code  = `BIS_CODE_AIRFLOW;
          end
          else
            restart = 1'b1;
        end
        else if (!held && phase_secs >= cfg.prepurge_s)
          next_state = st_pilot;
      st_pilot:
        if (!demand)
          next_state = st_standby;
        else if (!airflow)
          next_state = jumpers.airflow_lockout ?
                       st_lockout : st_prepurge;
        else if (held && flameout_secs >= `BIS_FLAMEOUT_S)
        begin
          next_state = st_lockout;
          next_code  = `BIS_CODE_FLAMEOUT;
        end
        else if (phase_secs >= trial_len)
        begin
          if (!flame)
          begin
            next_state = st_lockout;
            next_code  = `BIS_CODE_NO_FLAME;
          end
          else
            next_state = cfg.interrupted_pilot ?
                         st_main_trial : st_run;
        end
      st_main_trial, st_run:
        if (!demand)
          next_state = (state == st_run && cfg.post_purge) ?
                       st_postpurge : st_standby;
        else if (!airflow)
          next_state = jumpers.airflow_lockout ?
                       st_lockout : st_prepurge;
        else if (flame_fail)
        begin
          next_state = jumpers.flame_lockout ?
                       st_lockout : st_standby;
          next_code  = `BIS_CODE_FLAME_FAIL;
        end
        else if (state == st_main_trial &&
                 phase_secs >= `BIS_MAIN_TRIAL_S)
          next_state = st_run;
      st_postpurge:
        if (phase_secs >= `BIS_POSTPURGE_S)
          next_state = st_standby;
      st_lockout:
        if (lockout_reset)
        begin
          next_state = st_initiate;
          next_code  = `BIS_CODE_NONE;
        end
      st_fault:
        next_state = st_fault;
      default:
        next_state = st_initiate;
    endcase
    // Lockout with airflow open is an airflow lockout; a stale code
    // left by a recycle must not hide a later airflow lockout
    if (next_state == st_lockout && state != st_lockout && !airflow)
      next_code = `BIS_CODE_AIRFLOW;
    // Jumper tamper overrides everything, no way out
    if (jumper_fault)
    begin
      next_state = st_fault;
      next_code  = `BIS_CODE_JUMPER;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= st_initiate;
      fault_code <= `BIS_CODE_NONE;
    end
    else
    begin
      state      <= next_state;
      fault_code <= next_code;
    end
  end

  // Phase timer, cleared on every change, frozen while held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      phase_secs <= 8'h00;
    else if (next_state != state || restart)
      phase_secs <= 8'h00;
    else if (tick && !held && phase_secs != 8'hff)
      phase_secs <= phase_secs + 8'h01;
  end

  // Flameout timer while the pilot is held in test
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flameout_secs <= 8'h00;
    else if (state != st_pilot || !held || flame)
      flameout_secs <= 8'h00;
    else if (tick && flameout_secs != 8'hff)
      flameout_secs <= flameout_secs + 8'h01;
  end

  // Flame proven once per pilot trial
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flame_proven <= 1'b0;
    else if (state != st_pilot)
      flame_proven <= 1'b0;
    else if (flame)
      flame_proven <= 1'b1;
  end

  // Flame loss timer once the main valve is open
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loss_count <= 27'h0000000;
    else if (flame || (state != st_main_trial && state != st_run))
      loss_count <= 27'h0000000;
    else if (!flame_fail)
      loss_count <= loss_count + 27'h0000001;
  end

  // Operating seconds; jumper reference follows until the lock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_secs    <= 20'h00000;
      jumper_ref <= 3'h0;
    end
    else
    begin
      if (tick && !lock_passed)
        op_secs <= op_secs + 20'h00001;
      if (!lock_passed)
        jumper_ref <= jumpers;
    end
  end

  // Outputs follow the state one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      outs <= 6'h00;
    else
    begin
      outs.pilot    <= state == st_pilot ||
                       state == st_main_trial ||
                       (state == st_run && !cfg.interrupted_pilot);
      outs.ignition <= state == st_pilot && !flame_proven &&
                       !flame;
      outs.main     <= state == st_main_trial ||
                       state == st_run;
      outs.delayed_main <= state == st_run && cfg.delayed_main;
      outs.blower   <= state == st_prepurge || state == st_pilot ||
                       state == st_main_trial || state == st_run ||
                       state == st_postpurge;
      outs.alarm    <= state == st_lockout || state == st_fault;
    end
  end

  assign pilot_valve        = outs.pilot;
  assign ignition           = outs.ignition;
  assign main_valve         = outs.main;
  assign delayed_main_valve = outs.delayed_main;
  assign blower             = outs.blower;
  assign alarm              = outs.alarm;

  // Bus slave: zero wait states, so the answer is always OKAY
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address held over into the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Configuration register and lockout reset pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg           <= `BIS_CONFIG_RESET;
      lockout_reset <= 1'b0;
    end
    else
    begin
      lockout_reset <= wr_pend && wr_addr == `BIS_ADDR_CONTROL &&
                       hwdata[`BIS_CTRL_RESET_BIT];
      if (wr_pend && wr_addr == `BIS_ADDR_CONFIG)
        cfg <= hwdata[`BIS_CONFIG_MSB:0];
    end
  end

  // Read data captured at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (accept && !hwrite)
      case (haddr[7:0])
        `BIS_ADDR_CONFIG:  hrdata <= {19'h00000, cfg};
        `BIS_ADDR_STATUS:  hrdata <= {3'h0, flame, demand, airflow,
                                      run_test, held, 2'h0, outs,
                                      fault_code, 4'h0, state};
        `BIS_ADDR_SECONDS: hrdata <= {12'h000, op_secs};
        default:           hrdata <= 32'h00000000;
      endcase
  end

endmodule
`default_nettype wire

// >>> sim/bis_seq_asserts.sv
`include "bis_consts.svh"
`default_nettype none
module bis_seq_asserts
#(
  parameter int unsigned TICK_CYCLES  = 10,
  parameter int unsigned FAST_CYCLES  = 4,
  parameter int unsigned SLOW_CYCLES  = 8,
  parameter int unsigned LOCK_SECONDS = 20
)(
  input wire logic hclk,               // Clock
  input wire logic hresetn,            // Reset, low
  input wire logic flame,              // Flame in
  input wire logic demand,             // Demand in
  input wire logic run_test,           // Test switch
  input wire logic pilot_valve,        // Pilot out
  input wire logic ignition,           // Spark out
  input wire logic main_valve,         // Main out
  input wire logic delayed_main_valve, // Second stage
  input wire logic blower,             // Fan out
  input wire logic alarm               // Alarm out
);
  // One tick of slack for tick phase, two for output lag
  localparam int unsigned TRIAL_MAX =
    (`BIS_TRIAL_LONG_S + 1) * TICK_CYCLES + 2;
  int unsigned trial_cnt;
  int unsigned loss_cnt;

  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Pilot-only time; cleared in test, where a hold may stretch it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trial_cnt <= 0;
    else if (pilot_valve && !main_valve && !run_test)
      trial_cnt <= trial_cnt + 1;
    else
      trial_cnt <= 0;
  end

  // Main fuel open with no flame seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loss_cnt <= 0;
    else if (main_valve && !flame)
      loss_cnt <= loss_cnt + 1;
    else
      loss_cnt <= 0;
  end

  sequence s_valves_off;
    !pilot_valve && !main_valve && !delayed_main_valve;
  endsequence
  sequence s_all_off;
    s_valves_off ##0 !ignition;
  endsequence

  property p_ign_start;
    $rose(pilot_valve) && !$past(flame) |-> ignition;
  endproperty
  a_ign_start: assert property (p_ign_start)
    else $error("ignition off at pilot start");
  property p_blower;
    pilot_valve |-> blower;
  endproperty
  a_blower: assert property (p_blower)
    else $error("pilot open without blower");
  property p_trial_len;
    trial_cnt <= TRIAL_MAX;
  endproperty
  a_trial_len: assert property (p_trial_len)
    else $error("pilot trial too long");
  property p_ign_off;
    flame |=> !ignition;
  endproperty
  a_ign_off: assert property (p_ign_off)
    else $error("ignition kept on with flame");
  property p_main_flame;
    $rose(main_valve) |-> $past(flame, 2);
  endproperty
  a_main_flame: assert property (p_main_flame)
    else $error("main opened without flame");
  property p_flame_resp;
    loss_cnt <= SLOW_CYCLES + 3;
  endproperty
  a_flame_resp: assert property (p_flame_resp)
    else $error("main open too long after flame loss");
  property p_no_spark_main;
    main_valve |-> !ignition;
  endproperty
  a_no_spark_main: assert property (p_no_spark_main)
    else $error("ignition on with main valve");
  property p_delayed;
    delayed_main_valve |-> main_valve;
  endproperty
  a_delayed: assert property (p_delayed)
    else $error("delayed main without main");
  property p_demand_off;
    !demand |-> ##2 s_valves_off;
  endproperty
  a_demand_off: assert property (p_demand_off)
    else $error("valves open without demand");
  property p_alarm_safe;
    alarm |-> s_all_off;
  endproperty
  a_alarm_safe: assert property (p_alarm_safe)
    else $error("fuel or spark on during alarm");
endmodule
`default_nettype wire

// >>> sim/bis_plant.sv
`default_nettype none
module bis_plant
(
  input  wire logic hclk,        // Clock
  input  wire logic pilot_valve, // Pilot fuel
  input  wire logic main_valve,  // Main fuel
  input  wire logic blower,      // Fan
  input  wire logic lit_ok,      // Bench allows light-off
  input  wire logic air_ok,      // Bench allows air switch
  output logic      flame,       // Amplifier flame out
  output logic      airflow      // Interlock closed
);
  logic [7:0] lit_d = 8'h00;
  logic [7:0] air_d = 8'h00;

  // Slow light-off and fan spin-up, so spark is seen first
  always_ff @(posedge hclk)
  begin
    lit_d <= {lit_d[6:0], (pilot_valve | main_valve) & lit_ok};
    air_d <= {air_d[6:0], blower & air_ok};
  end
  assign flame   = lit_d[7];
  assign airflow = air_d[7];
endmodule
`default_nettype wire

// >>> sim/bis_sequencer_test.sv
`default_nettype none
module bis_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bis_pkg::*;
  localparam int TK   = 10;
  localparam int FAST = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, jmp;
  logic        flame, demand, airflow, run_test, lit_ok, air_ok;
  logic        pilot_valve, ignition, main_valve, delayed_main_valve;
  logic        blower, alarm;
  logic [5:0]  outs;
  int          error_cnt = 0;
  int          checks = 0;

  assign hready = hreadyout;
  assign outs = {pilot_valve, ignition, main_valve, delayed_main_valve,
                 blower, alarm};

  bis_sequencer #(.TICK_CYCLES(TK), .FAST_CYCLES(FAST), .SLOW_CYCLES(8),
                  .LOCK_SECONDS(20)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .flame, .demand, .airflow,
    .run_test, .trial_length_jumper(jmp[2]),
    .flame_fail_action_jumper(jmp[1]), .airflow_fail_action_jumper(jmp[0]),
    .pilot_valve, .ignition, .main_valve, .delayed_main_valve, .blower,
    .alarm);

  bis_plant plant_u (.hclk, .pilot_valve, .main_valve, .blower, .lit_ok,
                     .air_ok, .flame, .airflow);

  // Clock, 40 ns period
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic finish_test();
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single transfer; held until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Poll the state field; n is cycles spent, bounded
  task automatic wait_st(input logic [3:0] s, output int n);
    logic [31:0] q;
    q = 32'h0;
    for (n = 0; n < 3000; n += 2)
    begin
      rd(8'h08, q);
      if (q[3:0] === s)
        break;
    end
    chk(q[3:0], s);
  endtask

  // Timer run of s ticks, allowing tick phase and poll slack
  function automatic logic in_win(input int n, input int s);
    return n >= (s - 1) * TK - 3 && n <= s * TK + 4;
  endfunction

  // Jumpers set under reset, before their lock; s_jumper later changes them after the lock
  task automatic start(input logic [2:0] j);
    hresetn <= 1'b0;
    jmp <= j;
    {demand, run_test, lit_ok, air_ok} <= 4'h3;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    demand <= 1'b1;
  endtask

  task automatic s_regs();
    logic [31:0] q;
    start(3'h0);
    rd(8'h00, q);
    chk(q, 32'h140);
    chk(hresp, 1'b0);
    rd(8'h08, q);
    chk(q[21:0], 22'h0);
    wr(8'h00, 32'hffffffff);
    rd(8'h00, q);
    chk(q, 32'h1fff);
    rd(8'h04, q);
    chk(q, 32'h0);
    rd(8'h10, q);
    chk(q, 32'h0);
  endtask

  // Short trial, post-purge variant
  task automatic s_short();
    logic [31:0] q;
    int n;
    start(3'h4);
    wr(8'h00, 32'h144);
    wait_st(4'h3, n);
    chk(outs, 6'h32);
    repeat (12) @(posedge hclk);
    chk(outs, 6'h22);
    wait_st(4'h5, n);
    // Add the ignition wait and the first poll to the trial time
    chk(in_win(n + 14, 4), 1'b1);
    chk(main_valve, 1'b1);
    repeat (20 * TK) @(posedge hclk);
    rd(8'h08, q);
    chk(q[3:0], 4'h5);
    demand <= 1'b0;
    wait_st(4'h6, n);
    chk(outs, 6'h02);
    wait_st(4'h1, n);
    chk(in_win(n, 15), 1'b1);
    chk(outs, 6'h00);
  endtask

  task automatic s_no_flame();
    logic [31:0] q;
    int n;
    start(3'h0);
    lit_ok <= 1'b0;
    wait_st(4'h3, n);
    wait_st(4'h7, n);
    chk(in_win(n, 10), 1'b1);
    rd(8'h08, q);
    chk(q[15:8], 8'h01);
    chk(alarm, 1'b1);
    wr(8'h04, 32'h1);
    // Reset pulse is registered, state moves one edge later
    @(posedge hclk);
    rd(8'h08, q);
    chk(q[3:0], 4'h0);
  endtask

  // Interrupted pilot, delayed main, valves jumpered, flame lockout
  task automatic s_interrupt();
    logic [31:0] q;
    int n;
    start(3'h2);
    wr(8'h00, 32'h14b);
    wait_st(4'h3, n);
    run_test <= 1'b1;
    wait_st(4'h4, n);
    chk(in_win(n, 10), 1'b1);
    run_test <= 1'b0;
    wait_st(4'h5, n);
    chk(in_win(n, 10), 1'b1);
    chk(outs[5:2], 4'h3);
    chk(delayed_main_valve, 1'b1);
    lit_ok <= 1'b0;
    n = 0;
    while (main_valve === 1'b1 && n < 100)
    begin
      @(posedge hclk);
      if (flame === 1'b0)
        n++;
    end
    chk(n >= FAST && n <= FAST + 3, 1'b1);
    rd(8'h08, q);
    chk(q[15:0], 16'h0207);
  endtask

  task automatic s_air();
    logic [31:0] q;
    int n;
    start(3'h0);
    wait_st(4'h5, n);
    air_ok <= 1'b0;
    wait_st(4'h2, n);
    chk(n < 20, 1'b1);
    chk(alarm, 1'b0);
    air_ok <= 1'b1;
    wait_st(4'h5, n);
    lit_ok <= 1'b0;
    repeat (30) @(posedge hclk);
    rd(8'h08, q);
    chk({q[15:0], alarm}, 17'h404);
  endtask

  task automatic s_air_lock();
    logic [31:0] q;
    int n;
    start(3'h1);
    air_ok <= 1'b0;
    wait_st(4'h2, n);
    wait_st(4'h7, n);
    chk(in_win(n, 10), 1'b1);
    rd(8'h08, q);
    chk(q[15:8], 8'h03);
  endtask

  task automatic s_test();
    logic [31:0] q;
    int n;
    start(3'h0);
    lit_ok <= 1'b0;
    wait_st(4'h2, n);
    run_test <= 1'b1;
    repeat (20 * TK) @(posedge hclk);
    rd(8'h08, q);
    chk(q[3:0], 4'h2);
    chk(q[24], 1'b1);
    run_test <= 1'b0;
    wait_st(4'h3, n);
    run_test <= 1'b1;
    wait_st(4'h7, n);
    chk(in_win(n, 15), 1'b1);
    rd(8'h08, q);
    chk(q[15:8], 8'h04);
  endtask

  task automatic s_jumper();
    logic [31:0] q;
    int n;
    start(3'h0);
    repeat (30 * TK) @(posedge hclk);
    jmp <= 3'h2;
    wait_st(4'h8, n);
    chk(n < 8, 1'b1);
    wr(8'h04, 32'h1);
    rd(8'h08, q);
    chk(q[15:0], 16'h6e08);
    chk(alarm, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    {hsel, hwrite, demand, run_test, hresetn} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    jmp = 3'h0;
    {lit_ok, air_ok} = 2'h3;
    s_regs();
    s_short();
    s_no_flame();
    s_interrupt();
    s_air();
    s_air_lock();
    s_test();
    s_jumper();
    finish_test();
  end

  // Watchdog, well past the longest expected run
  initial
  begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    finish_test();
  end
endmodule

bind bis_sequencer bis_seq_asserts #(
  .TICK_CYCLES(TICK_CYCLES), .FAST_CYCLES(FAST_CYCLES),
  .SLOW_CYCLES(SLOW_CYCLES), .LOCK_SECONDS(LOCK_SECONDS)) asrt_u (
  .hclk, .hresetn, .flame, .demand, .run_test, .pilot_valve, .ignition,
  .main_valve, .delayed_main_valve, .blower, .alarm);
`default_nettype wire
